// ==== logic/uic_top.sv ====
// upstream isochrony control registers, window mapping and arbiter steer
module uic_top #(
    parameter logic [7:0] MAP_ID = 8'h5a,    // value is arbitrary
    parameter logic [7:0] REVISION = 8'h00   // value is arbitrary
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // register access
    input wire logic [uic_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [uic_pkg::BE_W-1:0] REG_BE,
    input wire logic [uic_pkg::DATA_W-1:0] REG_WDATA,
    output logic [uic_pkg::DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    // upstream transaction classing
    input wire logic UP_VALID,
    input wire logic [31:0] UP_ADDR,
    output logic UP_TC_VALID,
    output logic [2:0] UP_TC,
    output logic UP_WIN_HIT,
    // secondary bus arbiter steering
    input wire logic [uic_pkg::GNT_W-1:0] ARB_CLASSIC_GNT,
    input wire logic [uic_pkg::GNT_W-1:0] ARB_TABLE_GNT,
    input wire logic ARB_ISOC_URGENT,
    output logic [uic_pkg::GNT_W-1:0] ARB_GNT,
    output logic ARB_STOP_MASTER,
    output logic ARB_TABLE_MODE,
    output logic ARB_AGGRESSIVE,
    output logic ISOC_ENABLE
);
    import uic_pkg::*;

    // =========================================================
    // declarations
    logic [15:0] ctrl_r, ctrl_nxt;            // isochrony control
    logic [15:0] win_ctrl_r, win_ctrl_nxt;    // window 0 control
    logic [31:0] win_base_r, win_base_nxt;    // window 0 lower bound
    logic [31:0] win_limit_r, win_limit_nxt;  // window 0 upper bound
    logic [31:0] rdata_r, rdata_nxt;          // read answer
    logic rvalid_r, rvalid_nxt;               // read answer strobe
    logic tc_valid_r, tc_valid_nxt;           // classed request strobe
    logic [2:0] tc_r, tc_nxt;                 // class of request
    logic hit_r, hit_nxt;                     // request hit window
    logic [GNT_W-1:0] gnt_r, gnt_nxt;         // steered grants
    logic stop_r, stop_nxt;                   // stop current master
    logic [31:0] ctrl_merge;                  // control after byte merge
    logic [31:0] win_merge;                   // window control after merge
    logic win_hit;                            // matcher hit
    logic [2:0] win_tc;                       // matcher class
    logic [31:0] id_word;                     // word at offset 00h

    // =========================================================
    // byte lane merge of a write into an old word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // =========================================================
    // register write next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        win_ctrl_nxt = win_ctrl_r;
        win_base_nxt = win_base_r;
        win_limit_nxt = win_limit_r;
        ctrl_merge = merge({16'h0000, ctrl_r}, REG_WDATA, REG_BE);
        win_merge = merge({16'h0000, win_ctrl_r}, REG_WDATA, REG_BE);
        if (REG_WR) begin
            unique case (REG_ADDR)
                OFS_CTRL: begin
                    // reserved bits dropped on write
                    ctrl_nxt = ctrl_merge[15:0] & CTRL_USED_MASK;
                end
                OFS_WIN0_CTRL: begin
                    // enable and class kept, the rest read zero
                    win_ctrl_nxt = win_merge[15:0] & WIN_USED_MASK;
                end
                OFS_WIN0_BASE: begin
                    // plain storage whether or not the window is on
                    win_base_nxt = merge(win_base_r, REG_WDATA, REG_BE);
                end
                OFS_WIN0_LIMIT: begin
                    win_limit_nxt = merge(win_limit_r, REG_WDATA, REG_BE);
                end
                default: begin
                    // unmapped and read-only words ignore writes
                end
            endcase
        end
        // aggressive bit cannot stand without table arbitration
        if (!ctrl_nxt[CTRL_TABLE_BIT]) begin
            ctrl_nxt[CTRL_AGGR_BIT] = 1'b0;
        end
    end

    // register the control state
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_r <= CTRL_RST;
            win_ctrl_r <= WIN_CTRL_RST;
            win_base_r <= WIN_ADDR_RST;
            win_limit_r <= WIN_ADDR_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            win_ctrl_r <= win_ctrl_nxt;
            win_base_r <= win_base_nxt;
            win_limit_r <= win_limit_nxt;
        end
    end

    // =========================================================
    // read path
    always_comb begin
        id_word = 32'h0000_0000;
        id_word[MAP_ID_LSB +: 8] = MAP_ID;
        id_word[REV_LSB +: 8] = REVISION;
        id_word[CAP_LSB +: 4] = WINDOW_COUNT;
        rdata_nxt = 32'h0000_0000;
        rvalid_nxt = REG_RD;
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_MAP_ID: begin
                    rdata_nxt = id_word;
                end
                OFS_CTRL: begin
                    // upper half and reserved bits come back zero
                    rdata_nxt = {16'h0000, ctrl_r};
                end
                OFS_WIN0_CTRL: begin
                    rdata_nxt = {16'h0000, win_ctrl_r};
                end
                OFS_WIN0_BASE: begin
                    rdata_nxt = win_base_r;
                end
                OFS_WIN0_LIMIT: begin
                    rdata_nxt = win_limit_r;
                end
                default: begin
                    // unmapped offsets answer zero
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // register the read answer
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // =========================================================
    // upstream classing through window 0
    uic_window_match u_match (
        .addr(UP_ADDR),
        .isoc_en(ctrl_r[CTRL_ISOC_BIT]),
        .win_en(win_ctrl_r[WIN_EN_BIT]),
        .win_class(win_ctrl_r[WIN_TC_MSB:WIN_TC_LSB]),
        .base(win_base_r),
        .limit(win_limit_r),
        .hit(win_hit),
        .tc(win_tc)
    );

    // class next values, one cycle after the request
    always_comb begin
        tc_valid_nxt = UP_VALID;
        hit_nxt = UP_VALID && win_hit;
        tc_nxt = TC_ZERO;
        if (UP_VALID) begin
            // class zero unless the global enable lets mapping through
            tc_nxt = ctrl_r[CTRL_ISOC_BIT] ? win_tc : TC_ZERO;
        end
    end

    // =========================================================
    // arbiter steering
    always_comb begin
        if (ctrl_r[CTRL_TABLE_BIT]) begin
            // classic arbiter values ignored here
            gnt_nxt = ARB_TABLE_GNT;
        end else begin
            gnt_nxt = ARB_CLASSIC_GNT;
        end
        // aggressive mode cuts a master short when timing is at risk
        stop_nxt = ctrl_r[CTRL_AGGR_BIT] && ctrl_r[CTRL_TABLE_BIT]
            && ARB_ISOC_URGENT;
    end

    // register classing and steering outputs
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tc_valid_r <= 1'b0;
            tc_r <= TC_ZERO;
            hit_r <= 1'b0;
            gnt_r <= '0;
            stop_r <= 1'b0;
        end else begin
            tc_valid_r <= tc_valid_nxt;
            tc_r <= tc_nxt;
            hit_r <= hit_nxt;
            gnt_r <= gnt_nxt;
            stop_r <= stop_nxt;
        end
    end

    // =========================================================
    // outputs, each straight from a flip-flop
    assign REG_RDATA = rdata_r;
    assign REG_RVALID = rvalid_r;
    assign UP_TC_VALID = tc_valid_r;
    assign UP_TC = tc_r;
    assign UP_WIN_HIT = hit_r;
    assign ARB_GNT = gnt_r;
    assign ARB_STOP_MASTER = stop_r;
    assign ARB_TABLE_MODE = ctrl_r[CTRL_TABLE_BIT];
    assign ARB_AGGRESSIVE = ctrl_r[CTRL_AGGR_BIT];
    assign ISOC_ENABLE = ctrl_r[CTRL_ISOC_BIT];
endmodule

// ==== inc/uic_pkg.sv ====
// constants and register layout of the upstream isochrony control block
package uic_pkg;
    // =========================================================
    // register bus shape
    localparam int ADDR_W = 8;                       // byte address width
    localparam int DATA_W = 32;                      // register word width
    localparam int BE_W = 4;                         // byte enables
    localparam int GNT_W = 4;                        // secondary bus masters

    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_MAP_ID = 8'h00;       // id, revision, caps
    localparam logic [7:0] OFS_CTRL = 8'h04;         // isochrony control
    localparam logic [7:0] OFS_WIN0_CTRL = 8'h08;    // window 0 control
    localparam logic [7:0] OFS_WIN0_BASE = 8'h0c;    // window 0 base
    localparam logic [7:0] OFS_WIN0_LIMIT = 8'h10;   // window 0 limit

    // =========================================================
    // word at offset 00h
    localparam int MAP_ID_LSB = 0;                   // map id byte
    localparam int REV_LSB = 8;                      // revision byte
    localparam int CAP_LSB = 16;                     // capability half
    localparam logic [3:0] WINDOW_COUNT = 4'h4;      // four windows

    // =========================================================
    // isochrony control fields
    localparam int CTRL_ISOC_BIT = 0;                // global enable
    localparam int CTRL_TABLE_BIT = 1;               // table arbitration
    localparam int CTRL_AGGR_BIT = 2;                // aggressive mode
    localparam logic [15:0] CTRL_USED_MASK = 16'h0007;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // =========================================================
    // window control fields
    localparam int WIN_EN_BIT = 0;                   // window enable
    localparam int WIN_TC_LSB = 1;                   // class field low
    localparam int WIN_TC_MSB = 3;                   // class field high
    localparam logic [15:0] WIN_USED_MASK = 16'h000f;
    localparam logic [15:0] WIN_CTRL_RST = 16'h0000;
    localparam logic [31:0] WIN_ADDR_RST = 32'h0000_0000;

    // =========================================================
    // traffic classes
    localparam logic [2:0] TC_ZERO = 3'h0;           // default class
endpackage

// ==== logic/uic_window_match.sv ====
// address window compare and traffic class selection
module uic_window_match (
    // upstream request
    input wire logic [31:0] addr,
    // settings
    input wire logic isoc_en,
    input wire logic win_en,
    input wire logic [2:0] win_class,
    input wire logic [31:0] base,
    input wire logic [31:0] limit,
    // result
    output logic hit,
    output logic [2:0] tc
);
    import uic_pkg::*;

    // =========================================================
    // compare and select
    always_comb begin
        // inclusive bounds on both ends
        hit = win_en && isoc_en && (addr >= base) && (addr <= limit);
        if (hit) begin
            tc = win_class;
        end else begin
            // disabled window or global enable low keeps class zero
            tc = TC_ZERO;
        end
    end
endmodule

// ==== bench/uic_props.sv ====
// port checker for the upstream isochrony control block
module uic_props (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // register and upstream sides
    input wire logic REG_RD,
    input wire logic REG_RVALID,
    input wire logic [31:0] REG_RDATA,
    input wire logic UP_VALID,
    input wire logic UP_TC_VALID,
    input wire logic [2:0] UP_TC,
    input wire logic UP_WIN_HIT,
    // arbiter side
    input wire logic [3:0] ARB_CLASSIC_GNT,
    input wire logic [3:0] ARB_TABLE_GNT,
    input wire logic ARB_ISOC_URGENT,
    input wire logic [3:0] ARB_GNT,
    input wire logic ARB_STOP_MASTER,
    input wire logic ARB_TABLE_MODE,
    input wire logic ARB_AGGRESSIVE,
    input wire logic ISOC_ENABLE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // ==========================================================
    // register answers
    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read got no answer");
    a_rdata_idle: assert property (!REG_RD |=>
        !REG_RVALID && REG_RDATA == 32'h0) else $error("stray read data");
    // ==========================================================
    // arbiter steering
    a_aggr_needs_table: assert property (ARB_AGGRESSIVE |-> ARB_TABLE_MODE)
        else $error("aggressive without table mode");
    a_stop_cause: assert property ($past(RST_B) |-> ARB_STOP_MASTER ==
        ($past(ARB_AGGRESSIVE) && $past(ARB_ISOC_URGENT)))
        else $error("stop master mismatch");
    a_gnt_classic: assert property ($past(RST_B) && !$past(ARB_TABLE_MODE)
        |-> ARB_GNT == $past(ARB_CLASSIC_GNT)) else $error("classic grant");
    a_gnt_table: assert property ($past(RST_B) && $past(ARB_TABLE_MODE)
        |-> ARB_GNT == $past(ARB_TABLE_GNT)) else $error("table grant");
    // ==========================================================
    // upstream classing, then covers of stop, window hit and table grant
    a_class_answer: assert property (UP_VALID |=> UP_TC_VALID)
        else $error("request got no class");
    a_class_idle: assert property (!UP_VALID |=> !UP_TC_VALID &&
        UP_TC == 3'h0 && !UP_WIN_HIT) else $error("stray class output");
    a_class_zero_off: assert property (UP_VALID && !ISOC_ENABLE |=>
        UP_TC == 3'h0 && !UP_WIN_HIT) else $error("class while disabled");
    c_stop: cover property (ARB_STOP_MASTER);
    c_hit: cover property (UP_WIN_HIT && UP_TC != 3'h0);
    c_table: cover property (ARB_TABLE_MODE && ARB_GNT != 4'h0);
endmodule

bind uic_top uic_props chk_u (.SYS_CLK, .RST_B, .REG_RD, .REG_RVALID,
    .REG_RDATA, .UP_VALID, .UP_TC_VALID, .UP_TC, .UP_WIN_HIT,
    .ARB_CLASSIC_GNT, .ARB_TABLE_GNT, .ARB_ISOC_URGENT, .ARB_GNT,
    .ARB_STOP_MASTER, .ARB_TABLE_MODE, .ARB_AGGRESSIVE, .ISOC_ENABLE);

// ==== bench/uic_far_side.sv ====
// far side model: classic and table arbiters plus deadline flag
module uic_far_side (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // when high, grants change only now and then
    input wire logic slow,
    // toward the block
    output logic [3:0] classic_gnt = 4'h0,
    output logic [3:0] table_gnt = 4'h0,
    output logic urgent = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // changes land on the falling edge, away from the sampling edge
    always @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            classic_gnt <= 4'h0;
            table_gnt <= 4'h0;
            urgent <= 1'b0;
        end else if (!slow || $urandom % 4 == 0) begin
            // at most one master granted; a shift of four grants none
            classic_gnt <= 4'h1 << ($urandom % 5);
            table_gnt <= 4'h1 << ($urandom % 5);
            urgent <= 1'($urandom % 2);
        end
    end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the upstream isochrony control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uic_pkg::*;
    localparam logic [7:0] ID_V = 8'h3c;  // value is arbitrary
    localparam logic [7:0] REV_V = 8'h01; // value is arbitrary
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic REG_WR = 1'b0, REG_RD = 1'b0, UP_VALID = 1'b0, slow = 1'b0;
    logic [3:0] REG_BE = 4'h0;
    logic [31:0] REG_WDATA = 32'h0, UP_ADDR = 32'h0, REG_RDATA;
    logic REG_RVALID, UP_TC_VALID, UP_WIN_HIT, ARB_STOP_MASTER;
    logic ARB_TABLE_MODE, ARB_AGGRESSIVE, ISOC_ENABLE, ARB_ISOC_URGENT;
    logic [2:0] UP_TC;
    logic [3:0] ARB_CLASSIC_GNT, ARB_TABLE_GNT, ARB_GNT;
    int err_count = 0;
    int n_compared = 0;
    // reference copies of the registers
    logic [31:0] m_ctrl = 32'h0, m_win = 32'h0, m_base = 32'h0;
    logic [31:0] m_lim = 32'h0;
    // expected steering outputs, one edge behind the far side
    logic [3:0] e_gnt = 4'h0;
    logic e_stop = 1'b0;
    logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] edges[4] = '{32'h0fff, 32'h1000, 32'h1fff, 32'h2000};
    always #50 SYS_CLK = ~SYS_CLK;
    uic_top #(.MAP_ID(ID_V), .REVISION(REV_V)) dut_u (.SYS_CLK, .RST_B,
        .REG_ADDR, .REG_WR, .REG_RD, .REG_BE, .REG_WDATA, .REG_RDATA,
        .REG_RVALID, .UP_VALID, .UP_ADDR, .UP_TC_VALID, .UP_TC, .UP_WIN_HIT,
        .ARB_CLASSIC_GNT, .ARB_TABLE_GNT, .ARB_ISOC_URGENT, .ARB_GNT,
        .ARB_STOP_MASTER, .ARB_TABLE_MODE, .ARB_AGGRESSIVE, .ISOC_ENABLE);
    uic_far_side far_u (.clk(SYS_CLK), .rst_b(RST_B), .slow,
        .classic_gnt(ARB_CLASSIC_GNT), .table_gnt(ARB_TABLE_GNT),
        .urgent(ARB_ISOC_URGENT));
    function automatic logic [31:0] merge(input logic [31:0] o, d,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) o[8*i +: 8] = d[8*i +: 8];
        end
        return o;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one write; the reference follows at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        {REG_WR, REG_RD, UP_VALID} = 3'b100;
        {REG_ADDR, REG_BE, REG_WDATA} = {a, be, d};
        @(negedge SYS_CLK);
        case (a)
            OFS_CTRL: m_ctrl = merge(m_ctrl, d, be) & 32'h7;
            OFS_WIN0_CTRL: m_win = merge(m_win, d, be) & 32'hf;
            OFS_WIN0_BASE: m_base = merge(m_base, d, be);
            OFS_WIN0_LIMIT: m_lim = merge(m_lim, d, be);
            default: ;
        endcase
        if (!m_ctrl[1]) m_ctrl[2] = 1'b0;
        chk("mode bits", m_ctrl, {29'h0, ARB_AGGRESSIVE, ARB_TABLE_MODE,
            ISOC_ENABLE});
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        case (a)
            OFS_MAP_ID: e = {12'h000, 4'h4, REV_V, ID_V};
            OFS_CTRL: e = m_ctrl;
            OFS_WIN0_CTRL: e = m_win;
            OFS_WIN0_BASE: e = m_base;
            OFS_WIN0_LIMIT: e = m_lim;
            default: e = 32'h0;
        endcase
        {REG_WR, REG_RD, UP_VALID, REG_ADDR} = {3'b010, a};
        @(negedge SYS_CLK);
        chk("read valid", 32'h1, {31'h0, REG_RVALID});
        chk("read data", e, REG_RDATA);
    endtask
    task automatic up(input logic [31:0] a);
        logic hit;
        hit = m_ctrl[0] && m_win[0] && a >= m_base && a <= m_lim;
        {REG_WR, REG_RD, UP_VALID, UP_ADDR} = {3'b001, a};
        @(negedge SYS_CLK);
        chk("class valid", 32'h1, {31'h0, UP_TC_VALID});
        chk("window hit", {31'h0, hit}, {31'h0, UP_WIN_HIT});
        chk("class", hit ? {29'h0, m_win[3:1]} : 32'h0, {29'h0, UP_TC});
    endtask
    // steering reference: modes from the register copy, inputs of this edge
    always @(posedge SYS_CLK) begin
        e_gnt <= m_ctrl[1] ? ARB_TABLE_GNT : ARB_CLASSIC_GNT;
        e_stop <= m_ctrl[2] && m_ctrl[1] && ARB_ISOC_URGENT;
    end
    // compare steering outputs at every falling edge out of reset
    always @(negedge SYS_CLK) begin
        if (RST_B) begin
            chk("grant", {28'h0, e_gnt}, {28'h0, ARB_GNT});
            chk("stop master", {31'h0, e_stop}, {31'h0, ARB_STOP_MASTER});
        end
    end
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] b;
        void'($urandom(32'hfa012323));
        repeat (16) @(negedge SYS_CLK);
        RST_B = 1'b1;
        foreach (offs[i]) rd(offs[i]);
        wr(8'h04, 32'hffff_fffc, 4'hf);
        wr(8'h04, 32'hffff_ffff, 4'hf);
        rd(8'h04);
        wr(8'h04, 32'h0000_0005, 4'h1);
        wr(8'h00, 32'hffff_ffff, 4'hf);
        wr(8'h0c, 32'h0000_1000, 4'hf);
        wr(8'h10, 32'h0000_1fff, 4'hf);
        wr(8'h08, 32'hffff_fffb, 4'h3);
        foreach (edges[i]) up(edges[i]);
        wr(8'h04, 32'h0, 4'hf);
        up(32'h1800);
        wr(8'h04, 32'h1, 4'hf);
        wr(8'h08, 32'ha, 4'h1);
        up(32'h1800);
        for (int n = 0; n < 400; n++) begin
            b = $urandom;
            slow = b[31];
            case ($urandom % 4)
                0: wr(offs[$urandom % 6], b, 4'($urandom));
                1: rd(offs[$urandom % 6]);
                2: up(m_base + 32'($urandom % 3) - 32'h1);
                default: up(m_lim + 32'($urandom % 3) - 32'h1);
            endcase
        end
        {REG_WR, REG_RD, UP_VALID} = 3'b000;
        @(negedge SYS_CLK);
        conclude();
    end
endmodule
